/* File: core/pt32_pkg.sv */
// Constants for the paired 16/32-bit timer block.
package pt32_pkg;
	// Register offsets on the plain register port.
	localparam logic [15:0] OFF_LO_CNT = 16'h0106;
	localparam logic [15:0] OFF_HOLD = 16'h0108;
	localparam logic [15:0] OFF_HI_CNT = 16'h010A;
	localparam logic [15:0] OFF_LO_PER = 16'h010C;
	localparam logic [15:0] OFF_HI_PER = 16'h010E;
	localparam logic [15:0] OFF_CTL1 = 16'h0110;
	localparam logic [15:0] OFF_CTL2 = 16'h0112;
	localparam logic [15:0] OFF_IFLAG = 16'h0114;
	localparam logic [15:0] OFF_IEN = 16'h0116;
	// Control and flag field positions.
	localparam int B_ON = 15;
	localparam int B_SIDL = 13;
	localparam int B_GATE = 6;
	localparam int B_PS_HI = 5;
	localparam int B_PS_LO = 4;
	localparam int B_JOIN = 3;
	localparam int B_TCS = 1;
	localparam int B_FLAG_HI = 7;
	localparam int B_FLAG_LO = 6;
	// Writable bits; the rest read as zero.
	localparam logic [15:0] CTL1_MASK = 16'hA07A;
	localparam logic [15:0] CTL2_MASK = 16'hA072;
	localparam logic [15:0] FLAG_MASK = 16'h00C0;
	// Values after reset.
	localparam logic [15:0] RST_CNT = 16'h0000;
	localparam logic [15:0] RST_PER = 16'hFFFF;
	localparam logic [15:0] RST_CTL = 16'h0000;
	// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256.
	localparam logic [7:0] PS_TERM1 = 8'h00;
	localparam logic [7:0] PS_TERM8 = 8'h07;
	localparam logic [7:0] PS_TERM64 = 8'h3F;
	localparam logic [7:0] PS_TERM256 = 8'hFF;
endpackage

/* File: core/pt32_pin.sv */
// Synchroniser and edge finder for one external clock or gate pin.
`timescale 1ns/1ps
`default_nettype none
module pt32_pin (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Synchronised reset, active low.
	input wire logic i_pin, // External pin level.
	output logic o_level, // Synchronised level.
	output logic o_rise, // One-cycle pulse on rising edge.
	output logic o_fall // One-cycle pulse on falling edge.
);
	logic meta_reg;
	logic lvl_reg;
	logic prev_reg;

	// Two stages before use; only the second stage is looked at.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_reg <= 1'b0;
			lvl_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= i_pin;
			lvl_reg <= meta_reg;
			prev_reg <= lvl_reg;
		end
	end

	// Edges compare the settled level with its previous sample.
	assign o_level = lvl_reg;
	assign o_rise = lvl_reg & ~prev_reg;
	assign o_fall = ~lvl_reg & prev_reg;
endmodule
`default_nettype wire

/* File: core/pt32_prescale.sv */
// Four-step clock prescaler, optionally resynchronised at its output.
`timescale 1ns/1ps
`default_nettype none
module pt32_prescale #(
	parameter bit SYNC_OUT = 1'b0
) (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Synchronised reset, active low.
	input wire logic i_on, // Timer enabled; halts prescaler when low.
	input wire logic i_tick, // Input clock event.
	input wire logic i_clr, // Clear request from a register write.
	input wire logic [1:0] i_sel, // Division select.
	output logic o_tick // Divided clock event.
);
	logic [7:0] cnt_reg;
	logic sync_reg;
	wire [7:0] term = (i_sel == 2'h0) ? pt32_pkg::PS_TERM1 :
		(i_sel == 2'h1) ? pt32_pkg::PS_TERM8 :
		(i_sel == 2'h2) ? pt32_pkg::PS_TERM64 : pt32_pkg::PS_TERM256;
	wire raw = i_on & i_tick & (cnt_reg == term);

	// A halted prescaler cannot be cleared, so clears need i_on.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_reg <= 8'h00;
		else if (i_clr && i_on)
			cnt_reg <= 8'h00;
		else if (i_on && i_tick)
			cnt_reg <= raw ? 8'h00 : cnt_reg + 8'h01;
	end

	// The extra stage costs one cycle of latency but suits fast pins.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sync_reg <= 1'b0;
		else
			sync_reg <= raw;
	end

	assign o_tick = SYNC_OUT ? sync_reg : raw;
endmodule
`default_nettype wire

/* File: core/pt32_top.sv */
// Paired 16-bit timers that join into one 32-bit timer or counter.
`timescale 1ns/1ps
`default_nettype none
module pt32_top (
	input wire logic i_clk, // Instruction-cycle clock, 250 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic [15:0] i_addr, // Register address.
	input wire logic [15:0] i_wdata, // Register write data.
	input wire logic i_wr, // Write strobe.
	input wire logic i_rd, // Read strobe.
	output logic [15:0] o_rdata, // Read data, cycle after strobe.
	input wire logic i_pin_lo, // First half clock or gate pin.
	input wire logic i_pin_hi, // Second half clock or gate pin.
	input wire logic i_idle, // Processor in idle.
	input wire logic i_sleep, // Processor asleep.
	output logic o_adc_trig, // Converter trigger pulse.
	output logic o_irq // Interrupt request level.
);
	////////////////////////////////////////////////////////////////////
	// Reset release.
	logic rst_a_reg;
	logic rst_n_sync;

	// Assertion is immediate; release waits two edges.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_a_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end
		else
		begin
			rst_a_reg <= 1'b1;
			rst_n_sync <= rst_a_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers.
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	logic [15:0] hold_reg;
	logic [15:0] plo_reg;
	logic [15:0] phi_reg;
	logic [15:0] ctl1_reg;
	logic [15:0] ctl2_reg;
	logic [15:0] flag_reg;
	logic [15:0] ien_reg;
	logic [15:0] lo_next;
	logic [15:0] hi_next;
	logic [15:0] flag_next;

	// Address decode.
	wire wr_lo = i_wr & (i_addr == pt32_pkg::OFF_LO_CNT);
	wire wr_hold = i_wr & (i_addr == pt32_pkg::OFF_HOLD);
	wire wr_hi = i_wr & (i_addr == pt32_pkg::OFF_HI_CNT);
	wire wr_plo = i_wr & (i_addr == pt32_pkg::OFF_LO_PER);
	wire wr_phi = i_wr & (i_addr == pt32_pkg::OFF_HI_PER);
	wire wr_c1 = i_wr & (i_addr == pt32_pkg::OFF_CTL1);
	wire wr_c2 = i_wr & (i_addr == pt32_pkg::OFF_CTL2);
	wire wr_flag = i_wr & (i_addr == pt32_pkg::OFF_IFLAG);
	wire wr_ien = i_wr & (i_addr == pt32_pkg::OFF_IEN);
	wire rd_lo = i_rd & (i_addr == pt32_pkg::OFF_LO_CNT);

	////////////////////////////////////////////////////////////////////
	// Mode decode.
	wire join32 = ctl1_reg[pt32_pkg::B_JOIN];
	wire on1 = ctl1_reg[pt32_pkg::B_ON];
	wire on2 = ctl2_reg[pt32_pkg::B_ON] & ~join32;
	wire run = ~i_sleep;
	wire go1 = run & ~(i_idle & ctl1_reg[pt32_pkg::B_SIDL]);
	wire go2 = run & ~(i_idle & ctl2_reg[pt32_pkg::B_SIDL]);
	wire gate1 = ctl1_reg[pt32_pkg::B_GATE] & ~ctl1_reg[pt32_pkg::B_TCS];
	wire gate2 = ctl2_reg[pt32_pkg::B_GATE] & ~ctl2_reg[pt32_pkg::B_TCS] & ~join32;

	// Pin conditioning.
	logic lvl1;
	logic rise1;
	logic fall1;
	logic lvl2;
	logic rise2;
	logic fall2;

	pt32_pin u_pin_lo (
		.i_clk(i_clk),
		.i_rst_n(rst_n_sync),
		.i_pin(i_pin_lo),
		.o_level(lvl1),
		.o_rise(rise1),
		.o_fall(fall1)
	);

	pt32_pin u_pin_hi (
		.i_clk(i_clk),
		.i_rst_n(rst_n_sync),
		.i_pin(i_pin_hi),
		.o_level(lvl2),
		.o_rise(rise2),
		.o_fall(fall2)
	);

	// Clock events: synchronised pin edge, every cycle, or gated cycles.
	wire src1 = go1 & (ctl1_reg[pt32_pkg::B_TCS] ? rise1 : (~gate1 | lvl1));
	wire src2 = go2 & (ctl2_reg[pt32_pkg::B_TCS] ? rise2 : (~gate2 | lvl2));
	wire ps_clr = wr_lo | wr_hi | wr_c1 | wr_c2;

	////////////////////////////////////////////////////////////////////
	// Prescalers; the second one idles while the halves are joined.
	logic pre1;
	logic pre2;

	pt32_prescale #(.SYNC_OUT(1'b1)) u_pre_lo (
		.i_clk(i_clk),
		.i_rst_n(rst_n_sync),
		.i_on(on1),
		.i_tick(src1),
		.i_clr(ps_clr),
		.i_sel(ctl1_reg[pt32_pkg::B_PS_HI:pt32_pkg::B_PS_LO]),
		.o_tick(pre1)
	);

	pt32_prescale #(.SYNC_OUT(1'b0)) u_pre_hi (
		.i_clk(i_clk),
		.i_rst_n(rst_n_sync),
		.i_on(on2),
		.i_tick(src2),
		.i_clr(ps_clr),
		.i_sel(ctl2_reg[pt32_pkg::B_PS_HI:pt32_pkg::B_PS_LO]),
		.o_tick(pre2)
	);

	// The resynchronised tick is gated again so a late tick cannot slip in.
	wire inc_lo = pre1 & on1 & go1;
	wire inc_hi = pre2 & on2 & go2;

	////////////////////////////////////////////////////////////////////
	// Counting and period match.
	wire [31:0] cnt32 = {hi_reg, lo_reg};
	wire [31:0] per32 = {phi_reg, plo_reg};
	wire m32 = cnt32 == per32;
	wire m_lo = lo_reg == plo_reg;
	wire m_hi = hi_reg == phi_reg;
	wire [31:0] nx32 = m32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
	wire [15:0] nx_lo = m_lo ? 16'h0000 : lo_reg + 16'h0001;
	wire [15:0] nx_hi = m_hi ? 16'h0000 : hi_reg + 16'h0001;

	// Events.
	wire ev32 = join32 & inc_lo & m32;
	wire ev_lo = ~join32 & inc_lo & m_lo;
	wire ev_hi = inc_hi & m_hi;
	wire gf1 = on1 & gate1 & fall1;
	wire gf2 = on2 & gate2 & fall2;
	wire set7 = ev32 | ev_hi | (join32 & gf1) | gf2;
	wire set6 = ev_lo | (~join32 & gf1);

	// Register writes win over counting; control writes never touch counts.
	assign lo_next = wr_lo ? i_wdata :
		~inc_lo ? lo_reg :
		join32 ? nx32[15:0] : nx_lo;
	assign hi_next = wr_hi ? i_wdata :
		(wr_lo & join32) ? hold_reg :
		(join32 & inc_lo) ? nx32[31:16] :
		inc_hi ? nx_hi : hi_reg;

	// Hardware set wins over a software clear in the same cycle.
	assign flag_next = ((wr_flag ? (flag_reg & i_wdata) : flag_reg) |
		{8'h00, set7, set6, 6'h00}) & pt32_pkg::FLAG_MASK;

	// Counter state.
	always_ff @(posedge i_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			lo_reg <= pt32_pkg::RST_CNT;
			hi_reg <= pt32_pkg::RST_CNT;
		end
		else
		begin
			lo_reg <= lo_next;
			hi_reg <= hi_next;
		end
	end

	// Holding register: written by software, loaded by a low read.
	always_ff @(posedge i_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			hold_reg <= pt32_pkg::RST_CNT;
		else if (rd_lo)
			hold_reg <= hi_reg;
		else if (wr_hold)
			hold_reg <= i_wdata;
	end

	// Period and control registers.
	always_ff @(posedge i_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			plo_reg <= pt32_pkg::RST_PER;
			phi_reg <= pt32_pkg::RST_PER;
			ctl1_reg <= pt32_pkg::RST_CTL;
			ctl2_reg <= pt32_pkg::RST_CTL;
			ien_reg <= pt32_pkg::RST_CTL;
		end
		else
		begin
			if (wr_plo)
				plo_reg <= i_wdata;
			if (wr_phi)
				phi_reg <= i_wdata;
			if (wr_c1)
				ctl1_reg <= i_wdata & pt32_pkg::CTL1_MASK;
			if (wr_c2)
				ctl2_reg <= i_wdata & pt32_pkg::CTL2_MASK;
			if (wr_ien)
				ien_reg <= i_wdata & pt32_pkg::FLAG_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data and outputs.
	wire [15:0] rd_mux =
		(i_addr == pt32_pkg::OFF_LO_CNT) ? lo_reg :
		(i_addr == pt32_pkg::OFF_HOLD) ? hold_reg :
		(i_addr == pt32_pkg::OFF_HI_CNT) ? hi_reg :
		(i_addr == pt32_pkg::OFF_LO_PER) ? plo_reg :
		(i_addr == pt32_pkg::OFF_HI_PER) ? phi_reg :
		(i_addr == pt32_pkg::OFF_CTL1) ? ctl1_reg :
		(i_addr == pt32_pkg::OFF_CTL2) ? ctl2_reg :
		(i_addr == pt32_pkg::OFF_IFLAG) ? flag_reg :
		(i_addr == pt32_pkg::OFF_IEN) ? ien_reg : 16'h0000;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge i_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			o_rdata <= 16'h0000;
			flag_reg <= 16'h0000;
			o_adc_trig <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			o_rdata <= i_rd ? rd_mux : 16'h0000;
			flag_reg <= flag_next;
			o_adc_trig <= ev32 | ev_hi;
			o_irq <= |(flag_next & ien_reg);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n_sync);

	sequence hold_then_lo_s;
		(wr_hold && !rd_lo) ##1 (wr_lo && join32);
	endsequence

	hold_latch_a: assert property (rd_lo |=> hold_reg == $past(hi_reg))
		else $error("holding register missed the high count");

	coherent_write_a: assert property (hold_then_lo_s |=> hi_reg == $past(i_wdata, 2))
		else $error("low write did not copy holding value");

	ctl_keeps_cnt_a: assert property ((wr_c1 && !inc_lo) |=> lo_reg == $past(lo_reg))
		else $error("control write changed the count");

	sleep_still_a: assert property ((i_sleep && !i_wr) |=> $stable(cnt32))
		else $error("count moved during sleep");

	wrap_zero_a: assert property ((join32 && inc_lo && m32 && !i_wr) |=> cnt32 == 32'h0)
		else $error("joined counter did not wrap to zero");

	step_one_a: assert property ((join32 && inc_lo && !m32 && !i_wr)
		|=> cnt32 == $past(cnt32) + 32'h1)
		else $error("joined counter did not step by one");

	adc_pulse_a: assert property (ev32 |=> o_adc_trig)
		else $error("period match gave no converter trigger");

	flag_set_a: assert property ((ev32 || (join32 && gf1)) |=> flag_reg[pt32_pkg::B_FLAG_HI])
		else $error("interrupt flag not set");

	idle_stop_a: assert property ((i_idle && ctl1_reg[pt32_pkg::B_SIDL]) |-> !inc_lo)
		else $error("counting while idle with stop set");

	gate_low_a: assert property ((gate1 && !lvl1) |-> !src1)
		else $error("gated timer counted with gate low");

	join_hi_quiet_a: assert property (join32 |-> !inc_hi)
		else $error("second half counted on its own in joined mode");

	hold_copy_a: assert property ((wr_lo && join32) |=> hi_reg == $past(hold_reg))
		else $error("low write did not load the holding value");

	lo_wrap_a: assert property ((!join32 && inc_lo && m_lo && !i_wr)
		|=> lo_reg == 16'h0000)
		else $error("low half did not wrap at its period");

	hi_wrap_a: assert property ((inc_hi && m_hi && !i_wr) |=> hi_reg == 16'h0000)
		else $error("high half did not wrap at its period");

	lo_step_a: assert property ((!join32 && inc_lo && !m_lo && !i_wr)
		|=> lo_reg == $past(lo_reg) + 16'h0001)
		else $error("low half did not step by one");

	hi_step_a: assert property ((inc_hi && !m_hi && !i_wr)
		|=> hi_reg == $past(hi_reg) + 16'h0001)
		else $error("high half did not step by one");

	gate_stop_a: assert property (gf1 |=> !inc_lo)
		else $error("count went on after the gate fell");

	flag_hold_a: assert property ((!set7 && !wr_flag)
		|=> flag_reg[pt32_pkg::B_FLAG_HI] == $past(flag_reg[pt32_pkg::B_FLAG_HI]))
		else $error("interrupt flag changed without an event or a clear");

	trig_hi_a: assert property (ev_hi |=> o_adc_trig)
		else $error("second half match gave no converter trigger");

	trig_quiet_a: assert property (!(ev32 || ev_hi) |=> !o_adc_trig)
		else $error("converter trigger without a match");

	gate_ignore_a: assert property ((join32 && !gate1 && !ctl1_reg[pt32_pkg::B_TCS])
		|-> src1 == go1)
		else $error("joined timer gated by the second control");

	join_pre_a: assert property (join32 |-> !pre2)
		else $error("second prescaler ran in joined mode");

	sleep_quiet_a: assert property (i_sleep |-> !inc_lo && !inc_hi)
		else $error("counting while asleep");

	irq_on_a: assert property ((flag_reg[pt32_pkg::B_FLAG_HI]
		&& $past(ien_reg[pt32_pkg::B_FLAG_HI])) |-> o_irq)
		else $error("enabled flag gave no interrupt");

	irq_off_a: assert property (((flag_reg & $past(ien_reg)) == 16'h0000) |-> !o_irq)
		else $error("interrupt without an enabled flag");

	lo_still_a: assert property ((!inc_lo && !i_wr) |=> $stable(lo_reg))
		else $error("low count moved without a tick or a write");

	hi_still_a: assert property ((!inc_hi && !(join32 && inc_lo) && !i_wr)
		|=> $stable(hi_reg))
		else $error("high count moved without a tick or a write");

	idle_hi_a: assert property ((i_idle && ctl2_reg[pt32_pkg::B_SIDL] && !join32)
		|-> !inc_hi)
		else $error("second half counted while idle with stop set");
endmodule
`default_nettype wire

/* File: verification/pt32_pin_src.sv */
// Model of the external clock or gate source on one timer pin.
`timescale 1ns/1ps
`default_nettype none
module pt32_pin_src (
	input wire logic i_clk, // System clock.
	input wire logic i_level, // Gate level outside bursts.
	input wire logic i_start, // Starts a burst of rising edges.
	input wire logic [3:0] i_n, // Rising edges in the burst.
	input wire logic i_slow, // Longer half period.
	output logic o_pin // Pin level.
);
	logic [3:0] left_reg = 4'h0;
	logic [2:0] cnt_reg = 3'h0;
	logic pin_reg = 1'b0;
	////////////////////////////////////////////////////////////////
	// Toggle each half period; a burst ends on a falling edge.
	always @(posedge i_clk)
	begin
		if (i_start)
		begin
			left_reg <= i_n;
			cnt_reg <= 3'h0;
			pin_reg <= 1'b0;
		end
		else if (left_reg != 4'h0)
		begin
			if (cnt_reg == (i_slow ? 3'h5 : 3'h1))
			begin
				cnt_reg <= 3'h0;
				pin_reg <= ~pin_reg;
				if (pin_reg)
					left_reg <= left_reg - 4'h1;
			end
			else
				cnt_reg <= cnt_reg + 3'h1;
		end
	end
	// The clock stands still between bursts, so the gate level shows.
	assign o_pin = (left_reg != 4'h0) ? pin_reg : i_level;
endmodule
`default_nettype wire

/* File: verification/test_paired_timer_32bit.sv */
// Self-checking bench for the paired 16/32-bit timer block.
`timescale 1ns/1ps
`default_nettype none
module test_paired_timer_32bit;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_idle = 1'b0;
	logic i_sleep = 1'b0;
	logic gate_lo = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	wire logic pin_lo;
	wire logic pin_hi;
	wire logic [15:0] o_rdata;
	wire logic o_adc_trig;
	wire logic o_irq;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] dv [4] = '{16'h0002, 16'h0010, 16'h0080, 16'h0200};
	////////////////////////////////////////////////////////////////
	// Design and the two pin sources.
	pt32_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_lo(pin_lo), .i_pin_hi(pin_hi),
		.i_idle(i_idle), .i_sleep(i_sleep), .o_adc_trig(o_adc_trig), .o_irq(o_irq));
	pt32_pin_src u_src_lo (.i_clk(i_clk), .i_level(gate_lo), .i_start(go), .i_n(4'h5),
		.i_slow(slow), .o_pin(pin_lo));
	pt32_pin_src u_src_hi (.i_clk(i_clk), .i_level(1'b0), .i_start(go), .i_n(4'h3),
		.i_slow(slow), .o_pin(pin_hi));
	// Clock and a watchdog that cuts a hang short.
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	// Bus tasks; strobes last one cycle and change after the edge.
	task wr(input logic [15:0] ad, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] ad, output logic [15:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task rc(input string nm, input logic [15:0] ad, input logic [15:0] e);
		logic [15:0] d;
		rd(ad, d);
		check(nm, d, e);
	endtask
	// Cycles until the next trigger pulse, bounded.
	task sync(output int c);
		c = 0;
		do
		begin
			@(posedge i_clk);
			#1 c++;
		end
		while (o_adc_trig !== 1'b1 && c < 3000);
	endtask
	// Full trigger interval; the first wait only lines up.
	task meas(output int c);
		sync(c);
		sync(c);
	endtask
	// Counts trigger pulses over a stretch where none may come.
	task quiet(output int k);
		k = 0;
		repeat (100)
		begin
			@(posedge i_clk);
			#1 if (o_adc_trig === 1'b1) k++;
		end
	endtask
	task done(input string nm);
		$display("test %s finished", nm);
	endtask
	task results();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rc("lo_cnt", pt32_pkg::OFF_LO_CNT, pt32_pkg::RST_CNT);
		rc("hi_cnt", pt32_pkg::OFF_HI_CNT, pt32_pkg::RST_CNT);
		rc("lo_per", pt32_pkg::OFF_LO_PER, pt32_pkg::RST_PER);
		rc("hi_per", pt32_pkg::OFF_HI_PER, pt32_pkg::RST_PER);
		rc("ctl1", pt32_pkg::OFF_CTL1, pt32_pkg::RST_CTL);
		rc("flags", pt32_pkg::OFF_IFLAG, 16'h0000);
		rc("unmapped", 16'h0100, 16'h0000);
		wr(pt32_pkg::OFF_CTL1, 16'hFFFF);
		rc("ctl1_mask", pt32_pkg::OFF_CTL1, pt32_pkg::CTL1_MASK);
		wr(pt32_pkg::OFF_CTL2, 16'hFFFF);
		rc("ctl2_mask", pt32_pkg::OFF_CTL2, pt32_pkg::CTL2_MASK);
		rc("ctl_keep", pt32_pkg::OFF_LO_CNT, 16'h0000);
		wr(pt32_pkg::OFF_CTL2, 16'h0000);
		done("reset");
		wr(pt32_pkg::OFF_CTL1, 16'h0008);
		wr(pt32_pkg::OFF_HOLD, 16'h0001);
		wr(pt32_pkg::OFF_LO_CNT, 16'hFFFE);
		rc("lo", pt32_pkg::OFF_LO_CNT, 16'hFFFE);
		rc("hold", pt32_pkg::OFF_HOLD, 16'h0001);
		rc("hi", pt32_pkg::OFF_HI_CNT, 16'h0001);
		wr(pt32_pkg::OFF_LO_PER, 16'h0000);
		wr(pt32_pkg::OFF_HI_PER, 16'h0002);
		wr(pt32_pkg::OFF_CTL1, 16'h8008);
		sync(n);
		check("carry", {15'h0000, n < 20}, 16'h0001);
		wr(pt32_pkg::OFF_CTL1, 16'h0008);
		rd(pt32_pkg::OFF_LO_CNT, a);
		rc("wrap_hi", pt32_pkg::OFF_HOLD, 16'h0000);
		done("coherent");
		wr(pt32_pkg::OFF_CTL1, 16'h0000);
		wr(pt32_pkg::OFF_HI_CNT, 16'h0000);
		wr(pt32_pkg::OFF_HI_PER, 16'h0001);
		for (int s = 0; s < 4; s++)
		begin
			wr(pt32_pkg::OFF_CTL2, 16'h8000 | (16'(s) << 4));
			meas(n);
			check("divide", n[15:0], dv[s]);
		end
		done("prescale");
		// Second control asks for 1:256 and idle stop; joined mode ignores it.
		wr(pt32_pkg::OFF_CTL2, 16'hA030);
		wr(pt32_pkg::OFF_CTL1, 16'h0008);
		wr(pt32_pkg::OFF_HOLD, 16'h0000);
		wr(pt32_pkg::OFF_LO_CNT, 16'h0000);
		wr(pt32_pkg::OFF_LO_PER, 16'h0002);
		wr(pt32_pkg::OFF_HI_PER, 16'h0000);
		wr(pt32_pkg::OFF_CTL1, 16'h8008);
		meas(n);
		check("joined", n[15:0], 16'h0003);
		@(posedge i_clk) i_idle <= 1'b1;
		meas(n);
		check("idle_run", n[15:0], 16'h0003);
		wr(pt32_pkg::OFF_CTL1, 16'hA008);
		quiet(n);
		check("idle_stop", n[15:0], 16'h0000);
		@(posedge i_clk) i_idle <= 1'b0;
		meas(n);
		check("resume", n[15:0], 16'h0003);
		@(posedge i_clk) i_sleep <= 1'b1;
		quiet(n);
		check("sleep", n[15:0], 16'h0000);
		@(posedge i_clk) i_sleep <= 1'b0;
		rc("flag", pt32_pkg::OFF_IFLAG, 16'h0080);
		wr(pt32_pkg::OFF_IEN, 16'h0080);
		@(posedge i_clk);
		#1 check("irq_on", {15'h0000, o_irq}, 16'h0001);
		wr(pt32_pkg::OFF_CTL1, 16'h0008);
		wr(pt32_pkg::OFF_IFLAG, 16'h0000);
		rc("flag_clr", pt32_pkg::OFF_IFLAG, 16'h0000);
		check("irq_off", {15'h0000, o_irq}, 16'h0000);
		done("joined");
		wr(pt32_pkg::OFF_LO_CNT, 16'h0000);
		wr(pt32_pkg::OFF_LO_PER, 16'hFFFF);
		wr(pt32_pkg::OFF_HI_PER, 16'hFFFF);
		wr(pt32_pkg::OFF_CTL2, 16'h8040);
		wr(pt32_pkg::OFF_CTL1, 16'h8048);
		rc("gate_low", pt32_pkg::OFF_LO_CNT, 16'h0000);
		@(posedge i_clk) gate_lo <= 1'b1;
		repeat (10) @(posedge i_clk);
		gate_lo <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(pt32_pkg::OFF_LO_CNT, a);
		repeat (5) @(posedge i_clk);
		rd(pt32_pkg::OFF_LO_CNT, b);
		check("gate_hold", b, a);
		check("gate_cnt", {15'h0000, a == 16'h0000}, 16'h0000);
		rc("gate_flag", pt32_pkg::OFF_IFLAG, 16'h0080);
		wr(pt32_pkg::OFF_IFLAG, 16'h0000);
		done("gate");
		// Joined mode ignores the second pin; unjoined halves count alone.
		for (int j = 1; j >= 0; j--)
		begin
			wr(pt32_pkg::OFF_CTL1, 16'h0008);
			wr(pt32_pkg::OFF_CTL2, 16'h0000);
			wr(pt32_pkg::OFF_HI_CNT, 16'h0000);
			wr(pt32_pkg::OFF_HOLD, 16'h0000);
			wr(pt32_pkg::OFF_LO_CNT, 16'h0000);
			wr(pt32_pkg::OFF_CTL1, (j == 1) ? 16'h800A : 16'h8002);
			wr(pt32_pkg::OFF_CTL2, 16'h8002);
			@(posedge i_clk);
			go <= 1'b1;
			slow <= (j == 0);
			@(posedge i_clk) go <= 1'b0;
			repeat (150) @(posedge i_clk);
			rc("ext_lo", pt32_pkg::OFF_LO_CNT, 16'h0005);
			if (j == 1)
				rc("ext_hold", pt32_pkg::OFF_HOLD, 16'h0000);
			else
				rc("ext_hi", pt32_pkg::OFF_HI_CNT, 16'h0003);
		end
		done("external");
		results();
	end
endmodule
`default_nettype wire
